// File: hdl/tmr_regs.svh
// Register offsets, field positions and reset values of the 8-bit timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_ADDR_W 8
`define TMR_OFF_CONTROL 8'h00
`define TMR_OFF_COUNT 8'h04
`define TMR_OFF_IRQ_MASK 8'h08
`define TMR_OFF_IRQ_FLAGS 8'h0c
`define TMR_OFF_PS_RESET 8'h10

`define TMR_SEL_MSB 2
`define TMR_OVF_IRQ_EN_BIT 0
`define TMR_OVF_FLAG_BIT 0
`define TMR_PS_RESET_BIT 0

`define TMR_SEL_RESET 3'h0
`define TMR_COUNT_RESET 8'h00
`define TMR_MASK_RESET 1'h0
`define TMR_FLAG_RESET 1'h0

`define TMR_PS_WIDTH 10
`define TMR_TAP_COUNT 4
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// File: hdl/tmr_pkg.sv
// Types shared by the timer modules
package tmr_pkg;

  typedef enum logic [2:0] {
    SEL_STOP = 3'b000,
    SEL_SYS = 3'b001,
    SEL_DIV8 = 3'b010,
    SEL_DIV64 = 3'b011,
    SEL_DIV256 = 3'b100,
    SEL_DIV1024 = 3'b101,
    SEL_EXT_FALL = 3'b110,
    SEL_EXT_RISE = 3'b111
  } tmr_clk_sel_t;

  typedef struct packed {
    tmr_clk_sel_t sel;
    logic [7:0] count;
    logic ovfIrqEn;
    logic ovfFlag;
    logic psrPulse;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } tmr_top_state_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic [3:0] tap;
  } tmr_ps_state_t;

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } tmr_sync_state_t;

endpackage : tmr_pkg

// File: hdl/tmr_tick_if.sv
// Tick sources between prescaler, pin synchroniser and timer core
`timescale 1ns/1ns
`default_nettype none
interface tmr_tick_if;
  logic psReset;
  logic [3:0] tap;
  logic risePulse;
  logic fallPulse;

  modport prescaler (input psReset, output tap);
  modport pinsync (output risePulse, output fallPulse);
  modport timer (output psReset, input tap, input risePulse, input fallPulse);
endinterface : tmr_tick_if
`default_nettype wire

// File: hdl/tmr_prescaler.sv
// Shared free-running 10-bit prescaler with registered tap pulses
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_prescaler
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  tmr_tick_if.prescaler ps
);
  localparam int TapBits [4] = '{3, 6, 8, 10};

  tmr_ps_state_t st_q;
  tmr_ps_state_t st_d;
  logic [3:0] tapNext;

  // One tap per divisor: fires once when its low bits are all ones
  for (genvar i = 0; i < `TMR_TAP_COUNT; i++) begin : g_tap
    assign tapNext[i] = &st_q.cnt[TapBits[i]-1:0];
  end

  // Runs regardless of any select; only a prescaler reset or reset_n restarts it
  always_comb begin
    st_d = st_q;
    st_d.cnt = st_q.cnt + 10'h001;
    st_d.tap = tapNext;
    if (ps.psReset) begin
      st_d.cnt = 10'h000;
      st_d.tap = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ps.tap = st_q.tap;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ps_restart_quiet_a: assert property (ps.psReset |=> (!ps.tap[0]) [*8])
    else $error("divide-by-8 tap fired too soon after prescaler reset");
  tap_nesting_a: assert property (ps.tap[3] |-> (ps.tap[2] && ps.tap[1] && ps.tap[0]))
    else $error("slow tap fired without the faster taps");
endmodule : tmr_prescaler
`default_nettype wire

// File: hdl/tmr_pin_sync.sv
// Count pin synchroniser and edge detector
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_sync
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic extCountPin,
  tmr_tick_if.pinsync sy
);
  logic latchStage_q;
  tmr_sync_state_t st_q;
  tmr_sync_state_t st_d;

  // Falling-edge stage acts like a latch open while the clock is high
  always_ff @(negedge clk_sys) begin
    if (!reset_n) begin
      latchStage_q <= 1'b0;
    end else begin
      latchStage_q <= extCountPin;
    end
  end

  // Half-cycle stage plus two rising-edge stages gives 1.5 to 2.5 cycles
  always_comb begin
    st_d.meta = latchStage_q;
    st_d.stable = st_q.meta;
    st_d.prev = st_q.stable;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edges are detected always, so the source select never sees stale history
  assign sy.risePulse = st_q.stable & ~st_q.prev;
  assign sy.fallPulse = ~st_q.stable & st_q.prev;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  rise_after_sync_a: assert property ($rose(st_q.meta) |=> sy.risePulse ##1 !sy.risePulse)
    else $error("rising pin edge did not give exactly one pulse");
  fall_after_sync_a: assert property ($fell(st_q.meta) |=> sy.fallPulse ##1 !sy.fallPulse)
    else $error("falling pin edge did not give exactly one pulse");
endmodule : tmr_pin_sync
`default_nettype wire

// File: hdl/tmr_timer8.sv
// 8-bit timer core with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic extCountPin,
  input wire logic globalIrqEnable,
  input wire logic irqVectorTaken,
  input wire logic otherPsReset,
  output logic irqRequest,
  output logic [3:0] prescalerTaps
);
  localparam tmr_top_state_t TopReset = '{
    sel: tmr_clk_sel_t'(`TMR_SEL_RESET),
    count: `TMR_COUNT_RESET,
    ovfIrqEn: `TMR_MASK_RESET,
    ovfFlag: `TMR_FLAG_RESET,
    default: '0
  };

  tmr_top_state_t st_q;
  tmr_top_state_t st_d;
  tmr_tick_if tickBus ();

  logic tick;
  logic wrEn;
  logic wrControl;
  logic wrCount;
  logic wrMask;
  logic wrFlags;
  logic wrPsr;
  logic ovf;

  // Shared prescaler; its taps also serve the other timer
  tmr_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ps(tickBus.prescaler)
  );

  // Pin path feeds the counter directly, never through the prescaler
  tmr_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .extCountPin(extCountPin),
    .sy(tickBus.pinsync)
  );

  // Either timer's software can restart the shared prescaler
  assign tickBus.psReset = st_q.psrPulse | otherPsReset;
  assign prescalerTaps = tickBus.tap;

  // Source select turns one chosen pulse into the timer tick enable
  function automatic logic selectTick(
    input tmr_clk_sel_t sel,
    input logic [3:0] tap,
    input logic rise,
    input logic fall
  );
    unique case (sel)
      SEL_STOP: selectTick = 1'b0;
      SEL_SYS: selectTick = 1'b1;
      SEL_DIV8: selectTick = tap[0];
      SEL_DIV64: selectTick = tap[1];
      SEL_DIV256: selectTick = tap[2];
      SEL_DIV1024: selectTick = tap[3];
      SEL_EXT_FALL: selectTick = fall;
      SEL_EXT_RISE: selectTick = rise;
    endcase
  endfunction : selectTick

  // Register read view; unused bits and the prescaler reset read zero
  function automatic logic [31:0] readReg(
    input logic [7:0] addr,
    input tmr_top_state_t s
  );
    readReg = 32'h0;
    case (addr)
      `TMR_OFF_CONTROL: readReg[`TMR_SEL_MSB:0] = s.sel;
      `TMR_OFF_COUNT: readReg[7:0] = s.count;
      `TMR_OFF_IRQ_MASK: readReg[`TMR_OVF_IRQ_EN_BIT] = s.ovfIrqEn;
      `TMR_OFF_IRQ_FLAGS: readReg[`TMR_OVF_FLAG_BIT] = s.ovfFlag;
      default: readReg = 32'h0;
    endcase
  endfunction : readReg

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == `TMR_OFF_CONTROL) || (addr == `TMR_OFF_COUNT) ||
               (addr == `TMR_OFF_IRQ_MASK) || (addr == `TMR_OFF_IRQ_FLAGS) ||
               (addr == `TMR_OFF_PS_RESET);
  endfunction : isMapped

  // Tick is a same-clock enable, no derived clock anywhere
  assign tick = selectTick(st_q.sel, tickBus.tap, tickBus.risePulse, tickBus.fallPulse);

  // Write strobes; only byte lane 0 carries register bits
  assign wrEn = st_q.awHeld & st_q.wHeld & ~st_q.bValid & st_q.wStrb[0];
  assign wrControl = wrEn && (st_q.awAddr == `TMR_OFF_CONTROL);
  assign wrCount = wrEn && (st_q.awAddr == `TMR_OFF_COUNT);
  assign wrMask = wrEn && (st_q.awAddr == `TMR_OFF_IRQ_MASK);
  assign wrFlags = wrEn && (st_q.awAddr == `TMR_OFF_IRQ_FLAGS);
  assign wrPsr = wrEn && (st_q.awAddr == `TMR_OFF_PS_RESET) && st_q.wData[`TMR_PS_RESET_BIT];

  // An overwritten count cannot overflow in the same cycle
  assign ovf = tick && (st_q.count == 8'hff) && !wrCount;

  // Address and data are held separately so either may arrive first
  assign awready = ~st_q.awHeld;
  assign wready = ~st_q.wHeld;
  assign arready = ~st_q.rValid;
  assign bvalid = st_q.bValid;
  assign bresp = st_q.bResp;
  assign rvalid = st_q.rValid;
  assign rdata = st_q.rData;
  assign rresp = st_q.rResp;

  assign irqRequest = globalIrqEnable & st_q.ovfIrqEn & st_q.ovfFlag;

  // Next-state logic for counter, flags and bus slave
  always_comb begin
    st_d = st_q;
    st_d.psrPulse = 1'b0;

    // Counter: CPU write first, otherwise one step per tick
    if (wrCount) begin
      st_d.count = st_q.wData[7:0];
    end else if (tick) begin
      st_d.count = st_q.count + 8'h01;
    end

    // Flag clears come first so a same-cycle overflow still sets it
    if (irqVectorTaken) begin
      st_d.ovfFlag = 1'b0;
    end
    if (wrFlags && st_q.wData[`TMR_OVF_FLAG_BIT]) begin
      st_d.ovfFlag = 1'b0;
    end
    if (ovf) begin
      st_d.ovfFlag = 1'b1;
    end

    if (wrControl) begin
      st_d.sel = tmr_clk_sel_t'(st_q.wData[`TMR_SEL_MSB:0]);
    end
    if (wrMask) begin
      st_d.ovfIrqEn = st_q.wData[`TMR_OVF_IRQ_EN_BIT];
    end
    // One-cycle pulse; the bit itself is never stored
    if (wrPsr) begin
      st_d.psrPulse = 1'b1;
    end

    // Write address and data capture
    if (awvalid && !st_q.awHeld) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = awaddr;
    end
    if (wvalid && !st_q.wHeld) begin
      st_d.wHeld = 1'b1;
      st_d.wData = wdata;
      st_d.wStrb = wstrb;
    end

    // Write completes once both halves are in and no response waits
    if (st_q.awHeld && st_q.wHeld && !st_q.bValid) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = isMapped(st_q.awAddr) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end

    // Read answers one cycle after the address is taken
    if (arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rData = readReg(araddr, st_q);
      st_d.rResp = isMapped(araddr) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q <= TopReset;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence psrPulseSeq;
    st_q.psrPulse ##1 !st_q.psrPulse;
  endsequence

  sequence wrapSeq;
    (st_q.count == 8'h00) && st_q.ovfFlag;
  endsequence

  // Counter, flag, request gating and prescaler reset pulse behaviour
  count_write_wins_a: assert property (wrCount |=> st_q.count == $past(st_q.wData[7:0]))
    else $error("counter did not take the written value");
  overflow_sets_flag_a: assert property (ovf |=> wrapSeq)
    else $error("overflow did not wrap to zero and set the flag");
  stopped_holds_a: assert property ((st_q.sel == SEL_STOP) && !wrCount |=> $stable(st_q.count))
    else $error("stopped counter moved");
  sys_counts_a: assert property ((st_q.sel == SEL_SYS) && !wrCount |=>
                                 st_q.count == $past(st_q.count) + 8'h01)
    else $error("system clock source did not count every cycle");
  ext_rise_counts_a: assert property ((st_q.sel == SEL_EXT_RISE) && tickBus.risePulse && !wrCount |=>
                                      st_q.count == $past(st_q.count) + 8'h01)
    else $error("rising pin edge did not advance the counter");
  irq_mask_gate_a: assert property (!st_q.ovfIrqEn || !globalIrqEnable |-> !irqRequest)
    else $error("interrupt requested while masked");
  vector_clears_a: assert property (irqVectorTaken && !ovf |=> !st_q.ovfFlag)
    else $error("vector did not clear the overflow flag");
  psr_self_clear_a: assert property (wrPsr |=> psrPulseSeq)
    else $error("prescaler reset pulse was not exactly one cycle");
  // Register slave answers a read one cycle after taking the address, a write one cycle after holding both halves
  write_answer_a: assert property (st_q.awHeld && st_q.wHeld && !st_q.bValid |=> bvalid)
    else $error("write response missing one cycle after both halves");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing one cycle after address");

  // Pin sources step only on their own edge pulse, never on a prescaler tap
  ext_fall_counts_a: assert property ((st_q.sel == SEL_EXT_FALL) && tickBus.fallPulse && !wrCount |=>
                                      st_q.count == $past(st_q.count) + 8'h01)
    else $error("falling pin edge did not advance the counter");
  ext_rise_idle_a: assert property ((st_q.sel == SEL_EXT_RISE) && !tickBus.risePulse && !wrCount |=>
                                    $stable(st_q.count))
    else $error("rising pin source moved without a pin edge");
  ext_fall_idle_a: assert property ((st_q.sel == SEL_EXT_FALL) && !tickBus.fallPulse && !wrCount |=>
                                    $stable(st_q.count))
    else $error("falling pin source moved without a pin edge");

  // Divide-by-8 source steps exactly on its tap and holds otherwise
  div8_step_a: assert property ((st_q.sel == SEL_DIV8) && !wrCount |=>
                                st_q.count == $past(st_q.count) + {7'h0, $past(tickBus.tap[0])})
    else $error("divide-by-8 source did not follow its tap");

  // Register writes land one cycle after the write strobe
  mask_write_a: assert property (wrMask |=> st_q.ovfIrqEn == $past(st_q.wData[`TMR_OVF_IRQ_EN_BIT]))
    else $error("mask write did not land");
  flag_clear_a: assert property (wrFlags && st_q.wData[`TMR_OVF_FLAG_BIT] && !ovf |=> !st_q.ovfFlag)
    else $error("writing one did not clear the overflow flag");
  select_write_a: assert property (wrControl |=> st_q.sel == $past(st_q.wData[`TMR_SEL_MSB:0]))
    else $error("select write did not land");

  // Own prescaler reset clears every tap two cycles after the write
  sequence psRestartSeq;
    st_q.psrPulse ##1 (tickBus.tap == 4'h0);
  endsequence

  psr_restart_a: assert property (wrPsr |=> psRestartSeq)
    else $error("prescaler reset did not restart the taps");
endmodule : tmr_timer8
`default_nettype wire

// File: tb/tmr_pin_src.sv
// External event source that drives the timer count pin
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_src (
  input wire logic clk_sys,
  output logic pinOut
);
  // A driven line, so it keeps its level between events; idles low
  initial begin
    pinOut = 1'b0;
  end

  // Level changes land 10 ns after a rising edge, never on it
  task automatic set_level(input logic v);
    @(posedge clk_sys);
    #10;
    pinOut = v;
  endtask : set_level

  // Each half period lasts h clocks; callers never use h below 3
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      set_level(1'b1);
      repeat (h - 1) @(posedge clk_sys);
      set_level(1'b0);
      repeat (h - 1) @(posedge clk_sys);
    end
    // Pin rests before anyone switches the source
    repeat (2) @(posedge clk_sys);
  endtask : pulses
endmodule : tmr_pin_src
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the 8-bit timer and its register slave
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module testbench;
  logic clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irqRequest;
  logic extCountPin, globalIrqEnable, irqVectorTaken, otherPsReset;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lfsrState;
  logic [3:0] wstrb, prescalerTaps;
  logic [1:0] bresp, rresp;
  logic [41:0] rq[$];
  logic [1:0] bq[$];
  int bad_count, n_checks, t;
  int divs[4] = '{8, 64, 256, 1024};

  // Free-running 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  tmr_timer8 dut (.clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .extCountPin(extCountPin), .globalIrqEnable(globalIrqEnable),
    .irqVectorTaken(irqVectorTaken), .otherPsReset(otherPsReset), .irqRequest(irqRequest),
    .prescalerTaps(prescalerTaps));
  tmr_pin_src src (.clk_sys(clk_sys), .pinOut(extCountPin));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // Response watcher: oldest note against each handed-over answer
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      n_checks++;
      if ({rresp, rdata} !== rq[0][33:0]) begin
        $display("FAIL read %h exp %h got %h", rq[0][41:34], rq[0][33:0], {rresp, rdata});
        bad_count++;
      end
      void'(rq.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      n_checks++;
      if (bresp !== bq[0]) begin
        $display("FAIL bresp exp %h got %h", bq[0], bresp);
        bad_count++;
      end
      void'(bq.pop_front());
    end
  end

  // Address and data offered together, each dropped once taken; a hang is left to the watchdog
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `TMR_RESP_OKAY);
    bq.push_back(er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  // Waits for the read answer as long as it takes
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = `TMR_RESP_OKAY);
    rq.push_back({a, er, ed});
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // Preload 0xff, start the source, count clocks until the request shows
  task automatic set_ovf(input logic [2:0] sel, output int w);
    wr(`TMR_OFF_CONTROL, 32'h0);
    wr(`TMR_OFF_IRQ_FLAGS, 32'h1);
    wr(`TMR_OFF_COUNT, 32'hff);
    wr(`TMR_OFF_CONTROL, {29'h0, sel});
    w = 0;
    #1;
    while (irqRequest !== 1'b1 && w < 1100) begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    wr(`TMR_OFF_CONTROL, 32'h0);
  endtask : set_ovf

  // Clocks from now until tap k next pulses
  task automatic wait_tap(input int k, output int w);
    w = 0;
    do begin
      @(posedge clk_sys);
      #1;
      w++;
    end while (prescalerTaps[k] !== 1'b1 && w < 1100);
  endtask : wait_tap

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, globalIrqEnable, irqVectorTaken, otherPsReset} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    reset_n = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`TMR_OFF_CONTROL, 32'h0);
    rd(`TMR_OFF_COUNT, 32'h0);
    rd(`TMR_OFF_IRQ_MASK, 32'h0);
    rd(`TMR_OFF_IRQ_FLAGS, 32'h0);
    wr(8'h14, 32'hffffffff, `TMR_RESP_SLVERR);
    rd(8'h14, 32'h0, `TMR_RESP_SLVERR);
    rd(8'h02, 32'h0, `TMR_RESP_SLVERR);
    // Only the select field is writable in control
    wr(`TMR_OFF_CONTROL, 32'hffffffff);
    rd(`TMR_OFF_CONTROL, 32'h7);
    wr(`TMR_OFF_CONTROL, 32'h0);
    // Random counts held while stopped
    lfsrState = 32'h1395d192;
    repeat (4) begin
      lfsrState = lfsr_next(lfsrState);
      wr(`TMR_OFF_COUNT, lfsrState);
      repeat (20) @(posedge clk_sys);
      rd(`TMR_OFF_COUNT, {24'h0, lfsrState[7:0]});
    end
    // Overflow flag and request gating
    wr(`TMR_OFF_IRQ_MASK, 32'h1);
    globalIrqEnable <= 1'b1;
    set_ovf(3'd1, t);
    chk("sysclk overflow delay", 32'd0, t);
    wr(`TMR_OFF_IRQ_FLAGS, 32'h0);
    rd(`TMR_OFF_IRQ_FLAGS, 32'h1);
    globalIrqEnable <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("irq without global", 32'h0, {31'h0, irqRequest});
    globalIrqEnable <= 1'b1;
    wr(`TMR_OFF_IRQ_MASK, 32'h0);
    #1;
    chk("irq masked", 32'h0, {31'h0, irqRequest});
    wr(`TMR_OFF_IRQ_MASK, 32'h1);
    #1;
    chk("irq enabled", 32'h1, {31'h0, irqRequest});
    @(posedge clk_sys);
    irqVectorTaken <= 1'b1;
    @(posedge clk_sys);
    irqVectorTaken <= 1'b0;
    #1;
    chk("irq after vector", 32'h0, {31'h0, irqRequest});
    set_ovf(3'd1, t);
    chk("sysclk overflow again", 32'd0, t);
    wr(`TMR_OFF_IRQ_FLAGS, 32'h1);
    #1;
    chk("irq after flag clear", 32'h0, {31'h0, irqRequest});
    rd(`TMR_OFF_IRQ_FLAGS, 32'h0);
    // Prescaled sources, first tick within the divisor
    for (int s = 2; s < 6; s++) begin
      set_ovf(s[2:0], t);
      chk("prescaled first tick", 32'h1, {31'h0, t <= divs[s - 2]});
    end
    // Taps run while the timer is stopped
    for (int k = 0; k < 4; k++) begin
      wait_tap(k, t);
      wait_tap(k, t);
      chk("tap period", divs[k], t);
    end
    // Both reset paths restart the long tap from zero
    wait_tap(3, t);
    repeat (500) @(posedge clk_sys);
    otherPsReset <= 1'b1;
    @(posedge clk_sys);
    otherPsReset <= 1'b0;
    wait_tap(3, t);
    chk("tap after other reset", 32'h1, {31'h0, t > 1015 && t < 1030});
    repeat (500) @(posedge clk_sys);
    wr(`TMR_OFF_PS_RESET, 32'h1);
    wait_tap(3, t);
    chk("tap after own reset", 32'h1, {31'h0, t > 1015 && t < 1030});
    rd(`TMR_OFF_PS_RESET, 32'h0);
    // Pin counting, rising then falling
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_CONTROL, 32'h7);
    src.pulses(5, 3);
    wr(`TMR_OFF_CONTROL, 32'h0);
    rd(`TMR_OFF_COUNT, 32'h5);
    wr(`TMR_OFF_COUNT, 32'h0);
    wr(`TMR_OFF_CONTROL, 32'h6);
    src.set_level(1'b1);
    repeat (6) @(posedge clk_sys);
    rd(`TMR_OFF_COUNT, 32'h0);
    src.set_level(1'b0);
    repeat (6) @(posedge clk_sys);
    rd(`TMR_OFF_COUNT, 32'h1);
    // Pin edge to counter delay
    wr(`TMR_OFF_CONTROL, 32'h0);
    wr(`TMR_OFF_IRQ_FLAGS, 32'h1);
    wr(`TMR_OFF_COUNT, 32'hff);
    wr(`TMR_OFF_CONTROL, 32'h7);
    src.set_level(1'b1);
    t = 0;
    while (irqRequest !== 1'b1 && t < 8) begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    chk("pin edge delay", 32'd3, t);
    wr(`TMR_OFF_CONTROL, 32'h0);
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
